// File: rtl/iwp_ctrl.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module iwp_ctrl import iwp_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address, data and response
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// event sources
	input wire logic timer0_timeout,
	input wire logic timer1_timeout,
	input wire logic timer2_timeout,
	input wire logic port_b_bit2_pin,
	input wire logic port_b_bit4_pin,
	input wire logic port_b_bit0_pin,
	input wire logic stop_recovery_enable,
	// core facing status
	output logic interrupt_request_line,
	output logic [3:0] irq_vector,
	output logic cpu_clock_enable,
	output logic osc_enable,
	output logic core_reset,
	output logic [15:0] restart_addr
);
	// ==========================================
	// registers
	logic [1:0] cause_ff;
	logic stop_flag_ff;
	logic [7:0] interrupt_enable_register_ff;
	logic [7:0] tctl_ff;
	logic first_ff;
	logic [NREQ-1:0] pend_ff;
	logic pb2_ff, pb4_ff;
	iwp_mode_e mode_ff;
	logic [WDT_W-1:0] wdt_ff;
	logic wdt_fire;
	logic smr_fire;
	// ==========================================
	// axi4-lite slave: single outstanding write and read
	logic aw_hold_ff, w_hold_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic wr_go;
	assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// refused and unmapped writes are still answered okay
				s_axi_bresp <= 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready);
		end
	end
	logic wr_ok;
	logic [7:0] wb;
	assign wr_ok = wr_go && wstrb_ff[0];
	assign wb = wdata_ff[7:0];
	// core command strobes, one-cycle pulses written to the core register
	logic c_ei, c_di, c_enter, c_interrupt_return_instr, c_halt, c_stop, c_first;
	assign c_ei = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_EI];
	assign c_di = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_DI];
	assign c_enter = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_ENTER];
	assign c_interrupt_return_instr = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_INTERRUPT_RETURN_INSTR];
	assign c_halt = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_HALT];
	assign c_stop = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_STOP];
	assign c_first = wr_ok && awaddr_ff == OFS_CORE && wb[CMD_FIRST_DONE];
	// ==========================================
	// read channel
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h00000000;
		unique case (s_axi_araddr)
			OFS_CAUSE: rd_val = {29'h0, stop_flag_ff, cause_ff};
			OFS_MASK: rd_val = {24'h0, interrupt_enable_register_ff};
			OFS_TCTL: rd_val = {24'h0, tctl_ff};
			OFS_PEND: rd_val = {26'h0, pend_ff};
			OFS_CORE: rd_val = {27'h0, irq_vector, interrupt_request_line};
			default: rd_val = 32'h00000000;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				// unmapped addresses read zero with slverr
				s_axi_rresp <= (s_axi_araddr > OFS_CORE || s_axi_araddr[1:0] != 2'h0)
					? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ==========================================
	// reset cause and stop flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_ff <= CAUSE_POR; // RULE1
			stop_flag_ff <= 1'b0;
		end else begin
			if (wdt_fire)
				cause_ff <= CAUSE_WDT; // RULE25
			else if (smr_fire)
				cause_ff <= CAUSE_SMR; // RULE1
			// set wins over a simultaneous software clear; reads never touch it
			if (smr_fire)
				stop_flag_ff <= 1'b1; // RULE21
			else if (wr_ok && awaddr_ff == OFS_CAUSE && !wb[STOPFLAG_BIT])
				stop_flag_ff <= 1'b0; // RULE21
		end
	end
	// ==========================================
	// interrupt mask and global enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable_register_ff <= MASK_RST; // RULE9
		end else begin
			if (wr_ok && awaddr_ff == OFS_MASK)
				interrupt_enable_register_ff <= {wb[GIE_BIT], 1'b0, wb[NREQ-1:0]}; // RULE6
			if (c_enter || c_di)
				interrupt_enable_register_ff[GIE_BIT] <= 1'b0; // RULE8
			else if (c_ei || c_interrupt_return_instr)
				interrupt_enable_register_ff[GIE_BIT] <= 1'b1; // RULE8
		end
	end
	// ==========================================
	// timer control high; pin recovery leaves it untouched since only aresetn clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tctl_ff <= TCTL_RST; // RULE12 RULE13 RULE14
			first_ff <= 1'b1;
		end else begin
			if (wr_ok && awaddr_ff == OFS_TCTL) begin
				// reserved low bits forced to zero whatever software writes
				if (first_ff)
					tctl_ff <= wb & TCTL_UPPER; // RULE10 RULE15
			end
			if (c_first || (wr_ok && awaddr_ff == OFS_TCTL))
				first_ff <= 1'b0; // RULE10
		end
	end
	// ==========================================
	// edge detection and pending latches
	logic [NREQ-1:0] raw;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pb2_ff <= 1'b1;
			pb4_ff <= 1'b1;
		end else begin
			pb2_ff <= port_b_bit2_pin;
			pb4_ff <= port_b_bit4_pin;
		end
	end
	assign raw[0] = timer0_timeout; // RULE2
	assign raw[1] = pb4_ff && !port_b_bit4_pin; // RULE5
	assign raw[2] = timer1_timeout;
	assign raw[3] = pb2_ff && !port_b_bit2_pin; // RULE5
	assign raw[4] = !pb4_ff && port_b_bit4_pin; // RULE5
	assign raw[5] = timer2_timeout;
	logic [NREQ-1:0] grant;
	logic [NREQ-1:0] enabled;
	assign enabled = pend_ff & interrupt_enable_register_ff[NREQ-1:0] & {NREQ{interrupt_enable_register_ff[GIE_BIT]}}; // RULE6 RULE7
	always_comb begin
		grant = '0;
		for (int i = NREQ - 1; i >= 0; i--) begin
			if (enabled[i])
				grant = 6'(1 << i); // RULE3
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_ff <= '0;
		end else begin
			// a new edge in the acknowledge cycle is kept pending
			pend_ff <= raw | (pend_ff & ~(c_enter ? grant : 6'h00)); // RULE24
		end
	end
	// request numbers 6..15 can never appear: vector encodes only 0..5
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_request_line <= 1'b0;
			irq_vector <= 4'h0;
		end else begin
			interrupt_request_line <= |enabled; // RULE24
			irq_vector <= 4'h0; // RULE4
			for (int i = 0; i < NREQ; i++) begin
				if (grant[i])
					irq_vector <= 4'(2 * i + 2); // RULE2
			end
		end
	end
	// ==========================================
	// power modes
	assign smr_fire = mode_ff == IWP_STOP && stop_recovery_enable
		&& !port_b_bit0_pin; // RULE22
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= IWP_RUN;
		end else begin
			unique case (mode_ff)
				IWP_RUN: begin
					if (c_halt)
						mode_ff <= IWP_HALT; // RULE16
					else if (c_stop && !tctl_ff[STOPDIS_BIT])
						mode_ff <= IWP_STOP; // RULE14 RULE19
				end
				IWP_HALT: begin
					if (|enabled || wdt_fire)
						mode_ff <= IWP_RUN; // RULE17 RULE18
				end
				IWP_STOP: begin
					if (smr_fire)
						mode_ff <= IWP_RUN; // RULE20 RULE23
				end
				default: mode_ff <= IWP_RUN;
			endcase
		end
	end
	// ==========================================
	// watchdog: counts aclk as crystal clocks; held at zero in stop, and in halt unless bit 7 is set
	logic [WDT_W-1:0] wlim;
	logic wrun;
	assign wlim = iwp_wdt_limit(tctl_ff[WSEL_LSB+2:WSEL_LSB]); // RULE11
	assign wrun = wlim != '0 && mode_ff != IWP_STOP
		&& (mode_ff != IWP_HALT || tctl_ff[WHALT_BIT]); // RULE13
	assign wdt_fire = wrun && wdt_ff == wlim - 24'h000001; // RULE25
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wdt_ff <= '0;
		else if (!wrun || wdt_fire)
			wdt_ff <= '0;
		else
			wdt_ff <= wdt_ff + 24'h000001;
	end
	// ==========================================
	// core side outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset <= 1'b0;
			cpu_clock_enable <= 1'b1;
			osc_enable <= 1'b1;
			restart_addr <= RESTART_ADDR;
		end else begin
			core_reset <= wdt_fire || smr_fire; // RULE18 RULE20
			restart_addr <= RESTART_ADDR; // RULE18
			cpu_clock_enable <= mode_ff == IWP_RUN; // RULE16
			osc_enable <= mode_ff != IWP_STOP; // RULE19
		end
	end
endmodule : iwp_ctrl

// File: common/iwp_pkg.sv
// What this block does
// [RULE1] reset cause kept in two bits: 00 power/brownout, 01 stop recovery, 10 watchdog
// [RULE2] six requests with vectors 2,4,6,8,A,C from timers and port B edges
// [RULE3] fixed priority, request 0 highest, request 5 lowest
// [RULE4] request numbers six to fifteen are reserved, never raised
// [RULE5] external requests come from pin edges, not levels
// [RULE6] mask bits 0 to 5 enable their own request when 1
// [RULE7] mask bit 7 is global enable gating every request
// [RULE8] global enable set by ei, cleared by di and service entry, set by return
// [RULE9] interrupt mask resets to zero
// [RULE10] upper five timer control bits writable only during first instruction after reset
// [RULE11] watchdog select bits 6..4 choose time-out from disabled up to 8388608 clocks
// [RULE12] watchdog select resets to 001
// [RULE13] bit 7 keeps watchdog running in halt, resets to 1
// [RULE14] bit 3 resets set; set makes stop a no-op, clear enters stop
// [RULE15] software writes zero to reserved control bits 2..0
// [RULE16] halt stops cpu clock while timers and interrupt logic keep running
// [RULE17] enabled interrupt ends halt via its service routine
// [RULE18] reset or watchdog time-out ends halt, restart at 0020h
// [RULE19] stop shuts oscillator and system clock
// [RULE20] stop left only by power-on or stop recovery, restart at 0020h
// [RULE21] leaving stop sets stop flag; reads keep it, software write clears it
// [RULE22] low level held on port b bit 0 triggers stop recovery
// [RULE23] stop recovery by pin keeps control registers unchanged
// [RULE24] requests latch into pending bits; best enabled one presented to core
// [RULE25] watchdog expiry makes a reset and records watchdog cause
package iwp_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFS_CAUSE = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_TCTL = 8'h08;
	localparam logic [7:0] OFS_PEND = 8'h0C;
	localparam logic [7:0] OFS_CORE = 8'h10;
	// ==========================================
	// fields and reset values
	localparam int CAUSE_LSB = 0;
	localparam int STOPFLAG_BIT = 2;
	localparam logic [1:0] CAUSE_POR = 2'h0;
	localparam logic [1:0] CAUSE_SMR = 2'h1;
	localparam logic [1:0] CAUSE_WDT = 2'h2;
	localparam int GIE_BIT = 7;
	localparam int NREQ = 6;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam int WHALT_BIT = 7;
	localparam int WSEL_LSB = 4;
	localparam int STOPDIS_BIT = 3;
	localparam logic [7:0] TCTL_RST = 8'h98;
	localparam logic [7:0] TCTL_UPPER = 8'hF8;
	// core command bits in the core register
	localparam int CMD_EI = 0;
	localparam int CMD_DI = 1;
	localparam int CMD_ENTER = 2;
	localparam int CMD_INTERRUPT_RETURN_INSTR = 3;
	localparam int CMD_HALT = 4;
	localparam int CMD_STOP = 5;
	localparam int CMD_FIRST_DONE = 6;
	// ==========================================
	// timing: watchdog counts crystal clocks, one per aclk
	localparam int WDT_W = 24;
	localparam logic [15:0] RESTART_ADDR = 16'h0020;
	typedef enum logic [1:0] {IWP_RUN, IWP_HALT, IWP_STOP} iwp_mode_e;
	// watchdog limit for a select code, zero means disabled
	function automatic logic [WDT_W-1:0] iwp_wdt_limit(input logic [2:0] sel);
		unique case (sel)
			3'h0: iwp_wdt_limit = 24'h000000;
			3'h1: iwp_wdt_limit = 24'h010000;
			3'h2: iwp_wdt_limit = 24'h020000;
			3'h3: iwp_wdt_limit = 24'h040000;
			3'h4: iwp_wdt_limit = 24'h080000;
			3'h5: iwp_wdt_limit = 24'h100000;
			3'h6: iwp_wdt_limit = 24'h200000;
			default: iwp_wdt_limit = 24'h800000;
		endcase
	endfunction : iwp_wdt_limit
endpackage : iwp_pkg

// File: bench/iwp_ctrl_props.sv
`timescale 1ns/10ps
module iwp_ctrl_props import iwp_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched signals
	input wire logic s_axi_bvalid,
	input wire logic port_b_bit0_pin,
	input wire logic stop_recovery_enable,
	input wire logic interrupt_request_line,
	input wire logic [3:0] irq_vector,
	input wire logic cpu_clock_enable,
	input wire logic osc_enable,
	input wire logic core_reset,
	input wire logic [15:0] restart_addr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// =====
	// requests
	property p_vec;
		interrupt_request_line |-> irq_vector inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
	endproperty
	a_vec: assert property (p_vec) else $error("vector outside table");
	property p_novec;
		!interrupt_request_line |-> irq_vector == 4'h0;
	endproperty
	a_novec: assert property (p_novec) else $error("vector without request");
	// only a register write may withdraw a presented request
	property p_hold;
		interrupt_request_line && !s_axi_bvalid ##1 !s_axi_bvalid
			|-> interrupt_request_line;
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	// =====
	// power modes
	property p_addr;
		restart_addr == 16'h0020;
	endproperty
	a_addr: assert property (p_addr) else $error("restart address wrong");
	property p_osc;
		!osc_enable |-> !cpu_clock_enable;
	endproperty
	a_osc: assert property (p_osc) else $error("cpu clock without oscillator");
	// the oscillator flag lags the mode by one cycle, so the pin one cycle back decides
	property p_stay;
		!osc_enable && ($past(port_b_bit0_pin) || !$past(stop_recovery_enable))
			|=> !osc_enable;
	endproperty
	a_stay: assert property (p_stay) else $error("stop left without cause");
	property p_rec;
		!osc_enable && !port_b_bit0_pin && stop_recovery_enable |-> ##[1:8] osc_enable;
	endproperty
	a_rec: assert property (p_rec) else $error("no stop recovery");
	property p_wake;
		osc_enable && !cpu_clock_enable && interrupt_request_line
			|-> ##[0:3] cpu_clock_enable;
	endproperty
	a_wake: assert property (p_wake) else $error("halt not ended");
	property p_pulse;
		core_reset |=> !core_reset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
endmodule : iwp_ctrl_props
bind iwp_ctrl iwp_ctrl_props u_props (.*);

// File: bench/iwp_far.sv
`timescale 1ns/10ps
module iwp_far (
	// clock
	input wire logic aclk,
	// timer events
	output logic timer0_timeout,
	output logic timer1_timeout,
	output logic timer2_timeout,
	// port pins
	output logic port_b_bit2_pin,
	output logic port_b_bit4_pin,
	output logic port_b_bit0_pin,
	output logic stop_recovery_enable
);
	initial begin
		{timer2_timeout, timer1_timeout, timer0_timeout} = 3'h0;
		{port_b_bit2_pin, port_b_bit4_pin, port_b_bit0_pin} = 3'h7;
		stop_recovery_enable = 1'h1;
	end
	task automatic tmr(input int n);
		@(posedge aclk);
		{timer2_timeout, timer1_timeout, timer0_timeout} <= 3'(1 << n);
		@(posedge aclk);
		{timer2_timeout, timer1_timeout, timer0_timeout} <= 3'h0;
	endtask : tmr
	// pins are levels held until changed; only their edges may request
	task automatic pins(input logic [2:0] v);
		@(posedge aclk);
		{port_b_bit2_pin, port_b_bit4_pin, port_b_bit0_pin} <= v;
	endtask : pins
	// special function of the recovery pin, selected or not
	task automatic smr_en(input logic e);
		@(posedge aclk);
		stop_recovery_enable <= e;
	endtask : smr_en
endmodule : iwp_far

// File: bench/iwp_ctrl_tb.sv
`timescale 1ns/10ps
module iwp_ctrl_tb import iwp_pkg::*;;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, irq_vector;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
	logic timer0_timeout, timer1_timeout, timer2_timeout, port_b_bit2_pin, port_b_bit4_pin;
	logic port_b_bit0_pin, stop_recovery_enable, interrupt_request_line, cpu_clock_enable;
	logic osc_enable, core_reset;
	logic [15:0] restart_addr;
	int bad_count = 0, comparisons = 0;
	always #2.5 aclk = ~aclk;
	iwp_ctrl DUT (.*);
	iwp_far far (.*);
	// =====
	// bus access and checks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
		end while (!s_axi_bvalid);
		wrsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wrs
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wrs(a, d, 4'hF);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdr
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	// the minimum watchdog span dominates the run
	initial begin
		#400000;
		bad_count++;
		$display("unexpected at %0t: timeout", $time);
		print_verdict();
	end
	// =====
	// scenarios
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rdr(OFS_CAUSE);
		chk(rd, 32'h0);
		rdr(OFS_MASK);
		chk(rd, 32'(MASK_RST));
		rdr(OFS_TCTL);
		chk(rd, 32'h98);
		wr(OFS_TCTL, 32'h90);
		wr(OFS_TCTL, 32'h10);
		rdr(OFS_TCTL);
		chk(rd, 32'h90);
		wr(8'h14, 32'h1);
		chk(32'(wrsp), 32'h0);
		rdr(8'h14);
		chk(32'(rsp), 32'h2);
		// a write with byte 0 not strobed must leave the mask alone
		wrs(OFS_MASK, 32'h3F, 4'h0);
		rdr(OFS_MASK);
		chk(rd, 32'h0);
		wr(OFS_MASK, 32'h3F);
		far.tmr(0);
		far.tmr(1);
		far.tmr(2);
		far.pins(3'h1);
		far.pins(3'h3);
		repeat (3) @(posedge aclk);
		chk(32'(interrupt_request_line), 32'h0);
		wr(OFS_CORE, 32'h1 << CMD_EI);
		repeat (2) @(posedge aclk);
		chk(32'(interrupt_request_line), 32'h1);
		wr(OFS_CORE, 32'h1 << CMD_DI);
		repeat (2) @(posedge aclk);
		chk(32'(interrupt_request_line), 32'h0);
		wr(OFS_CORE, 32'h1 << CMD_EI);
		for (int i = 0; i < NREQ; i++) begin
			repeat (2) @(posedge aclk);
			chk({27'h0, irq_vector, interrupt_request_line}, 32'(4 * i + 5));
			wr(OFS_CORE, 32'h1 << CMD_ENTER);
			repeat (2) @(posedge aclk);
			chk(32'(interrupt_request_line), 32'h0);
			wr(OFS_CORE, 32'h1 << CMD_INTERRUPT_RETURN_INSTR);
		end
		repeat (3) @(posedge aclk);
		chk(32'(interrupt_request_line), 32'h0);
		wr(OFS_CORE, 32'h1 << CMD_HALT);
		repeat (2) @(posedge aclk);
		chk(32'({cpu_clock_enable, osc_enable}), 32'h1);
		far.tmr(0);
		for (int i = 0; i < 20 && !cpu_clock_enable; i++) @(posedge aclk);
		chk(32'({cpu_clock_enable, irq_vector}), 32'h12);
		wr(OFS_CORE, 32'h1 << CMD_ENTER);
		wr(OFS_CORE, 32'h1 << CMD_INTERRUPT_RETURN_INSTR);
		wr(OFS_CORE, 32'h1 << CMD_STOP);
		repeat (2) @(posedge aclk);
		chk(32'(osc_enable), 32'h0);
		// low pin without its special function must not wake the part
		far.smr_en(1'h0);
		far.pins(3'h2);
		repeat (4) @(posedge aclk);
		chk(32'(osc_enable), 32'h0);
		far.smr_en(1'h1);
		for (int i = 0; i < 20 && !osc_enable; i++) @(posedge aclk);
		chk(32'(osc_enable), 32'h1);
		far.pins(3'h3);
		rdr(OFS_CAUSE);
		chk(rd, 32'h5);
		rdr(OFS_CAUSE);
		chk(rd, 32'h5);
		rdr(OFS_TCTL);
		chk(rd, 32'h90);
		wr(OFS_CAUSE, 32'h0);
		rdr(OFS_CAUSE);
		chk(32'(rd[2]), 32'h0);
		// nothing pending, so only the watchdog can end this halt
		wr(OFS_CORE, 32'h1 << CMD_HALT);
		for (int i = 0; i < 70000 && !core_reset; i++) @(posedge aclk);
		repeat (2) @(posedge aclk);
		chk(32'(cpu_clock_enable), 32'h1);
		rdr(OFS_CAUSE);
		chk(32'(rd[1:0]), 32'(CAUSE_WDT));
		// second reset in mid-run: defaults return and the first-done command closes the write window
		aresetn <= 1'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rdr(OFS_CAUSE);
		chk(rd, 32'h0);
		wr(OFS_CORE, 32'h1 << CMD_STOP);
		repeat (2) @(posedge aclk);
		chk(32'(osc_enable), 32'h1);
		wr(OFS_CORE, 32'h1 << CMD_FIRST_DONE);
		wr(OFS_TCTL, 32'h10);
		rdr(OFS_TCTL);
		chk(rd, 32'h98);
		print_verdict();
	end
endmodule : iwp_ctrl_tb
